// ---- core/atxw_pkg.sv ----
// package: constants and types of the atx switch and host watchdog block
package atxw_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TICK_HZ = 32;
    localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;
    localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);
    // key hold, reset pulse and watchdog times in seconds/quarters, converted to 1/32 s ticks
    localparam logic [7:0] HOLD_LONG_S = 8'h04;
    localparam logic [7:0] HOLD_LONG_TICKS = 8'(HOLD_LONG_S * TICK_HZ);
    localparam logic [7:0] HOLD_SHORT_TICKS = 8'(TICK_HZ / 4);
    localparam logic [7:0] RESET_PULSE_TICKS = 8'(1 * TICK_HZ);
    localparam logic [7:0] EXTRA_HOLD_TICKS = 8'(5 * TICK_HZ);
    localparam logic [7:0] WDOG_TICKS_PER_S = 8'(TICK_HZ);
    // function mask bits
    localparam int unsigned FN_AUTO_POL = 0;
    localparam int unsigned FN_RST_INV = 1;
    localparam int unsigned FN_PWR_INV = 2;
    localparam int unsigned FN_WDOG_ACT = 3;
    localparam int unsigned FN_BLANK = 4;
    localparam int unsigned FN_KEY_RST = 5;
    localparam int unsigned FN_KEY_ON = 6;
    localparam int unsigned FN_KEY_OFF = 7;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] PULSE_LEN_RESET = 8'h20;
    localparam logic SENSE_SEL_RESET = 1'b1;
    localparam logic [1:0] STATUS_LEN_RESET = 2'h0;
    localparam logic [3:0] STATUS_LEN = 4'hf;
    localparam logic [3:0] STATUS_MASK_IDX = 4'h7;
    localparam logic [3:0] STATUS_WDOG_IDX = 4'h8;
    localparam logic [3:0] STATUS_SENSE_IDX = 4'hb;
    // synchronisers leave reset at 0; sense edges are trusted after this many cycles
    localparam logic [2:0] SENSE_SETTLE_CYCLES = 3'h7;
    typedef enum logic [2:0] {
        ATXW_IDLE = 3'h0,
        ATXW_SAMPLE = 3'h1,
        ATXW_PULSE = 3'h3,
        ATXW_EXTEND = 3'h2,
        ATXW_SELFRST = 3'h6
    } atxw_state_e;
    typedef enum logic [1:0] {
        ATXW_ACT_RST = 2'h0,
        ATXW_ACT_ON = 2'h1,
        ATXW_ACT_OFF = 2'h2
    } atxw_act_e;
endpackage : atxw_pkg

// ---- core/atxw_sync.sv ----
// three-stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/10ps
module atxw_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } atxw_sync_s;
    atxw_sync_s st_r;
    atxw_sync_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign level = st_r.lvl;
endmodule : atxw_sync

// ---- core/atxw_top.sv ----
// atx power/reset switch sequencer with host watchdog
`timescale 1ns/10ps
// Function
// (RL1) idle: reset and power lines undriven
// (RL2) pulse drives active level, ends undriven
// (RL3) confirm held 4 s: 1 s reset pulse
// (RL4) after keypad reset, ignore commands until self reset
// (RL5) confirm 0.25 s with host off: power pulse
// (RL6) cancel held 4 s: power-off pulse, up to 5 s more
// (RL7) blank display while host sense low
// (RL8) third byte selects sense source, default supply
// (RL9) host off: watch keys; sense rise reboots self
// (RL10) mask bits: auto polarity, reset/power invert
// (RL11) first byte is function enable mask
// (RL12) second byte: pulse length in 1/32 s
// (RL13) config carries 1 to 3 bytes
// (RL14) watchdog timeout zero disables it
// (RL15) host feeds watchdog within timeout seconds
// (RL16) watchdog expiry pulses host reset line (code: only when idle; expiry during a pulse just turns it off)
// (RL17) watchdog off at start and after firing
// (RL18) status mask shows watchdog active bit
// (RL19) status is 15 bytes, includes sense source
// (RL20) host sets pin 1 pull-up, non-user
// (RL21) host sets pins 2, 3 high impedance
// (RL22) host saves settings into boot state
// (RL23) auto polarity drives opposite of idle level
// (RL24) all timing from one 1/32 s tick
module atxw_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic key_confirm,
    input wire logic key_cancel,
    input wire logic sense_supply,
    input wire logic sense_pin1,
    input wire logic reset_line_in,
    input wire logic power_line_in,
    output logic reset_line_out,
    output logic reset_line_oe,
    output logic power_line_out,
    output logic power_line_oe,
    input wire logic cfg_valid,
    input wire logic [1:0] cfg_len,
    input wire logic [7:0] cfg_mask,
    input wire logic [7:0] cfg_pulse_len,
    input wire logic [7:0] cfg_sense_sel,
    input wire logic wdog_valid,
    input wire logic [7:0] wdog_timeout,
    input wire logic status_req,
    output logic status_valid,
    output logic [7:0] status_byte,
    output logic status_last,
    output logic cmd_blocked,
    output logic display_blank,
    output logic self_reset,
    output logic [1:0] msg_sel
);
    typedef struct packed {
        atxw_pkg::atxw_state_e state;
        atxw_pkg::atxw_act_e act;
        logic [18:0] div;
        logic tick;
        logic [7:0] hold_cnt;
        logic [7:0] pulse_cnt;
        logic [7:0] mask;
        logic [7:0] pulse_len;
        logic sense_sel;
        logic wdog_on;
        logic [7:0] wdog_cnt;
        logic [4:0] wdog_sub;
        logic drive_lvl;
        logic blocked;
        logic rst_out;
        logic rst_oe;
        logic pwr_out;
        logic pwr_oe;
        logic blank;
        logic self_rst;
        logic [1:0] msg;
        logic sense_d;
        logic [2:0] warm;
        logic st_busy;
        logic [3:0] st_idx;
        logic st_valid;
        logic [7:0] st_byte;
        logic st_last;
        logic [3:0] sv_run;
    } atxw_top_s;
    atxw_top_s st_r;
    atxw_top_s st_nxt;
    logic conf_s;
    logic canc_s;
    logic sup_s;
    logic pin1_s;
    logic rst_in_s;
    logic pwr_in_s;
    logic sense;
    atxw_sync u_sync_conf (.clk(clk), .reset(reset), .pin(key_confirm), .level(conf_s));
    atxw_sync u_sync_canc (.clk(clk), .reset(reset), .pin(key_cancel), .level(canc_s));
    atxw_sync u_sync_sup (.clk(clk), .reset(reset), .pin(sense_supply), .level(sup_s));
    atxw_sync u_sync_pin1 (.clk(clk), .reset(reset), .pin(sense_pin1), .level(pin1_s));
    atxw_sync u_sync_rin (.clk(clk), .reset(reset), .pin(reset_line_in), .level(rst_in_s));
    atxw_sync u_sync_pin (.clk(clk), .reset(reset), .pin(power_line_in), .level(pwr_in_s));
    assign sense = st_r.sense_sel ? sup_s : pin1_s; // RL8
    always_comb begin
        logic accept;
        logic wdog_fire;
        logic pol_bit;
        logic [7:0] st_mask;
        accept = 1'b0;
        wdog_fire = 1'b0;
        pol_bit = 1'b0;
        st_mask = 8'h00;
        st_nxt = st_r;
        st_nxt.self_rst = 1'b0;
        st_nxt.st_valid = 1'b0;
        st_nxt.st_last = 1'b0;
        st_nxt.sense_d = sense;
        // a live sense would look like a rise while the synchronisers fill
        if (st_r.warm != atxw_pkg::SENSE_SETTLE_CYCLES) begin
            st_nxt.warm = st_r.warm + 3'h1;
        end
        // length of the current unbroken status run, for the stream check
        st_nxt.sv_run = st_r.st_valid ? st_r.sv_run + 4'h1 : 4'h0;
        // common 1/32 s tick
        st_nxt.tick = (st_r.div == atxw_pkg::TICK_LAST); // RL24
        st_nxt.div = st_nxt.tick ? 19'h00000 : st_r.div + 19'h00001;
        accept = !st_r.blocked; // RL4
        if (accept && cfg_valid && cfg_len != 2'h0) begin
            st_nxt.mask = {cfg_mask[7:4], 1'b0, cfg_mask[2:0]}; // RL11 RL13
            if (cfg_len >= 2'h2) begin
                st_nxt.pulse_len = cfg_pulse_len; // RL12
            end
            if (cfg_len == 2'h3) begin
                st_nxt.sense_sel = cfg_sense_sel[0]; // RL8 RL13
            end
        end
        // watchdog countdown in whole seconds
        if (st_r.wdog_on && st_r.tick) begin
            st_nxt.wdog_sub = st_r.wdog_sub + 5'h01;
            if (st_r.wdog_sub == 5'(atxw_pkg::WDOG_TICKS_PER_S - 8'h01)) begin
                st_nxt.wdog_sub = 5'h00;
                if (st_r.wdog_cnt == 8'h01) begin
                    wdog_fire = 1'b1;
                end
                st_nxt.wdog_cnt = st_r.wdog_cnt - 8'h01;
            end
        end
        if (wdog_fire) begin
            st_nxt.wdog_on = 1'b0; // RL17
        end
        // a feed in the firing cycle wins: the host proved alive
        if (accept && wdog_valid) begin
            st_nxt.wdog_on = (wdog_timeout != 8'h00); // RL14
            st_nxt.wdog_cnt = wdog_timeout;
            st_nxt.wdog_sub = 5'h00;
            wdog_fire = 1'b0;
        end
        st_nxt.blank = st_r.mask[atxw_pkg::FN_BLANK] && !sense; // RL7
        if (!st_r.sense_d && sense && st_r.state == atxw_pkg::ATXW_IDLE
            && st_r.warm == atxw_pkg::SENSE_SETTLE_CYCLES) begin
            st_nxt.self_rst = 1'b1; // RL9
        end
        pol_bit = (st_r.act == atxw_pkg::ATXW_ACT_RST) ? st_r.mask[atxw_pkg::FN_RST_INV]
                                                      : st_r.mask[atxw_pkg::FN_PWR_INV];
        case (st_r.state)
            atxw_pkg::ATXW_IDLE: begin
                st_nxt.rst_oe = 1'b0; // RL1
                st_nxt.pwr_oe = 1'b0; // RL1
                st_nxt.msg = 2'h0;
                if (st_r.tick) begin
                    if ((conf_s && sense && st_r.mask[atxw_pkg::FN_KEY_RST])
                        || (conf_s && !sense && st_r.mask[atxw_pkg::FN_KEY_ON])
                        || (canc_s && sense && st_r.mask[atxw_pkg::FN_KEY_OFF])) begin
                        st_nxt.hold_cnt = st_r.hold_cnt + 8'h01;
                    end else begin
                        st_nxt.hold_cnt = 8'h00;
                    end
                end
                if (wdog_fire) begin
                    st_nxt.act = atxw_pkg::ATXW_ACT_RST; // RL16
                    st_nxt.state = atxw_pkg::ATXW_SAMPLE;
                end else if (conf_s && sense && st_r.mask[atxw_pkg::FN_KEY_RST]
                             && st_r.hold_cnt >= atxw_pkg::HOLD_LONG_TICKS) begin
                    st_nxt.act = atxw_pkg::ATXW_ACT_RST; // RL3
                    st_nxt.state = atxw_pkg::ATXW_SAMPLE;
                end else if (conf_s && !sense && st_r.mask[atxw_pkg::FN_KEY_ON]
                             && st_r.hold_cnt >= atxw_pkg::HOLD_SHORT_TICKS) begin
                    st_nxt.act = atxw_pkg::ATXW_ACT_ON; // RL5 RL9
                    st_nxt.state = atxw_pkg::ATXW_SAMPLE;
                end else if (canc_s && sense && st_r.mask[atxw_pkg::FN_KEY_OFF]
                             && st_r.hold_cnt >= atxw_pkg::HOLD_LONG_TICKS) begin
                    st_nxt.act = atxw_pkg::ATXW_ACT_OFF; // RL6
                    st_nxt.state = atxw_pkg::ATXW_SAMPLE;
                end
            end
            atxw_pkg::ATXW_SAMPLE: begin
                // idle level is read while the line is still undriven
                if (st_r.mask[atxw_pkg::FN_AUTO_POL]) begin
                    st_nxt.drive_lvl = (st_r.act == atxw_pkg::ATXW_ACT_RST)
                                       ? !rst_in_s : !pwr_in_s; // RL23
                end else begin
                    st_nxt.drive_lvl = pol_bit; // RL10
                end
                st_nxt.pulse_cnt = (st_r.act == atxw_pkg::ATXW_ACT_RST)
                                   ? atxw_pkg::RESET_PULSE_TICKS : st_r.pulse_len; // RL3 RL12
                st_nxt.hold_cnt = 8'h00;
                st_nxt.msg = 2'(st_r.act) + 2'h1;
                st_nxt.state = atxw_pkg::ATXW_PULSE;
            end
            atxw_pkg::ATXW_PULSE: begin
                if (st_r.act == atxw_pkg::ATXW_ACT_RST) begin
                    st_nxt.rst_oe = 1'b1; // RL2
                    st_nxt.rst_out = st_r.drive_lvl;
                end else begin
                    st_nxt.pwr_oe = 1'b1; // RL2
                    st_nxt.pwr_out = st_r.drive_lvl;
                end
                if (st_r.tick) begin
                    st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
                end
                if (st_r.pulse_cnt == 8'h00) begin
                    st_nxt.rst_oe = 1'b0; // RL2
                    if (st_r.act == atxw_pkg::ATXW_ACT_OFF && canc_s) begin
                        st_nxt.pulse_cnt = atxw_pkg::EXTRA_HOLD_TICKS; // RL6
                        st_nxt.state = atxw_pkg::ATXW_EXTEND;
                    end else begin
                        st_nxt.pwr_oe = 1'b0;
                        st_nxt.blocked = (st_r.act == atxw_pkg::ATXW_ACT_RST); // RL4
                        st_nxt.state = atxw_pkg::ATXW_SELFRST;
                    end
                end
            end
            atxw_pkg::ATXW_EXTEND: begin
                if (st_r.tick) begin
                    st_nxt.pulse_cnt = st_r.pulse_cnt - 8'h01;
                end
                if (!canc_s || st_r.pulse_cnt == 8'h00) begin
                    st_nxt.pwr_oe = 1'b0; // RL2 RL6
                    st_nxt.state = atxw_pkg::ATXW_SELFRST;
                end
            end
            atxw_pkg::ATXW_SELFRST: begin
                // power-off ends without rebooting; reset and power-on reboot
                st_nxt.self_rst = (st_r.act != atxw_pkg::ATXW_ACT_OFF); // RL3 RL5
                st_nxt.msg = 2'h0;
                st_nxt.state = atxw_pkg::ATXW_IDLE;
            end
            default: begin
                st_nxt.state = atxw_pkg::ATXW_IDLE;
            end
        endcase
        // debug status stream
        st_mask = st_r.mask;
        st_mask[atxw_pkg::FN_WDOG_ACT] = st_r.wdog_on; // RL18
        if (accept && status_req && !st_r.st_busy) begin
            st_nxt.st_busy = 1'b1;
            st_nxt.st_idx = 4'h0;
        end
        if (st_r.st_busy) begin
            st_nxt.st_valid = 1'b1;
            if (st_r.st_idx == atxw_pkg::STATUS_MASK_IDX) begin
                st_nxt.st_byte = st_mask;
            end else if (st_r.st_idx == atxw_pkg::STATUS_WDOG_IDX) begin
                st_nxt.st_byte = st_r.wdog_cnt; // RL18
            end else if (st_r.st_idx == atxw_pkg::STATUS_SENSE_IDX) begin
                st_nxt.st_byte = {7'h00, st_r.sense_sel}; // RL19
            end else begin
                st_nxt.st_byte = 8'h00;
            end
            st_nxt.st_idx = st_r.st_idx + 4'h1;
            if (st_r.st_idx == atxw_pkg::STATUS_LEN - 4'h1) begin
                st_nxt.st_last = 1'b1; // RL19
                st_nxt.st_busy = 1'b0;
            end
        end
        // self reset restores power-up defaults for the command block and the watchdog enable only
        if (st_r.self_rst) begin
            st_nxt.blocked = 1'b0;
            // a feed landing on the self-reset cycle arms the watchdog only if commands are not blocked, so not after a reset pulse
            if (!(accept && wdog_valid)) begin
                st_nxt.wdog_on = 1'b0; // RL17
            end
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.state <= atxw_pkg::ATXW_IDLE;
            st_r.act <= atxw_pkg::ATXW_ACT_RST;
            st_r.mask <= atxw_pkg::MASK_RESET;
            st_r.pulse_len <= atxw_pkg::PULSE_LEN_RESET;
            st_r.sense_sel <= atxw_pkg::SENSE_SEL_RESET;
            st_r.sense_d <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign reset_line_out = st_r.rst_out;
    assign reset_line_oe = st_r.rst_oe;
    assign power_line_out = st_r.pwr_out;
    assign power_line_oe = st_r.pwr_oe;
    assign status_valid = st_r.st_valid;
    assign status_byte = st_r.st_byte;
    assign status_last = st_r.st_last;
    assign cmd_blocked = st_r.blocked;
    assign display_blank = st_r.blank;
    assign self_reset = st_r.self_rst;
    assign msg_sel = st_r.msg;

    a_idle_undriven: assert property (@(posedge clk) disable iff (reset) // RL1
        st_r.state == atxw_pkg::ATXW_IDLE |=> !reset_line_oe && !power_line_oe)
        else $error("line driven while idle");
    a_blank_follow: assert property (@(posedge clk) disable iff (reset) // RL7
        (st_r.mask[atxw_pkg::FN_BLANK] && !sense) |=> display_blank)
        else $error("display not blanked with host down");
    a_wdog_zero: assert property (@(posedge clk) disable iff (reset) // RL14
        (!cmd_blocked && wdog_valid && wdog_timeout == 8'h00) |=> !st_r.wdog_on)
        else $error("zero timeout left watchdog on");
    a_blocked_cmd: assert property (@(posedge clk) disable iff (reset) // RL4
        (cmd_blocked && cfg_valid) |=> $stable(st_r.mask))
        else $error("command taken while blocked");
    sequence s_start;
        st_r.state == atxw_pkg::ATXW_IDLE ##1 st_r.state == atxw_pkg::ATXW_SAMPLE;
    endsequence
    a_pulse_drive: assert property (@(posedge clk) disable iff (reset) // RL2
        s_start |-> ##2 (reset_line_oe || power_line_oe))
        else $error("pulse did not drive line");
    // last byte must close an unbroken run: fourteen valid cycles before it
    a_status_len: assert property (@(posedge clk) disable iff (reset) // RL19
        (status_req && !st_r.st_busy && !cmd_blocked)
        |-> ##16 (status_last && st_r.sv_run == 4'he))
        else $error("status length wrong");
    a_wdog_flag: assert property (@(posedge clk) disable iff (reset) // RL18
        (status_valid && st_r.st_idx == atxw_pkg::STATUS_MASK_IDX + 4'h1)
        |-> status_byte[atxw_pkg::FN_WDOG_ACT] == $past(st_r.wdog_on))
        else $error("status watchdog bit wrong");
    a_tick_period: assert property (@(posedge clk) disable iff (reset) // RL24
        st_r.tick |=> !st_r.tick [*8])
        else $error("tick too frequent");
    a_auto_pol: assert property (@(posedge clk) disable iff (reset) // RL23
        (st_r.state == atxw_pkg::ATXW_SAMPLE && st_r.mask[atxw_pkg::FN_AUTO_POL]
         && st_r.act == atxw_pkg::ATXW_ACT_RST) |=> st_r.drive_lvl == !$past(rst_in_s))
        else $error("auto polarity wrong");
endmodule : atxw_top

// ---- sim/atxw_host_model.sv ----
// host motherboard model: pulled-up switch inputs and host power sense sources
`timescale 1ns/10ps
module atxw_host_model (
    input wire logic clk,
    input wire logic reset_line_out,
    input wire logic reset_line_oe,
    input wire logic power_line_out,
    input wire logic power_line_oe,
    input wire logic supply_on,
    input wire logic pin1_on,
    output logic reset_line_in,
    output logic power_line_in,
    output logic sense_supply,
    output logic sense_pin1,
    output logic [31:0] drive_cycles
);
    // the board pulls its switch inputs up; only the module's drive can move them
    assign reset_line_in = reset_line_oe ? reset_line_out : 1'b1;
    assign power_line_in = power_line_oe ? power_line_out : 1'b1;
    assign sense_supply = supply_on;
    // pin 1 rests on a pull-up and is pulled low while the host is down
    assign sense_pin1 = pin1_on;
    initial drive_cycles = 32'h0;
    // counts every cycle in which the module drives either line
    always @(posedge clk) begin
        if (reset_line_oe || power_line_oe) begin
            drive_cycles <= drive_cycles + 32'h1;
        end
    end
endmodule : atxw_host_model

// ---- sim/atxw_top_tb_top.sv ----
// testbench: command, status and host-sense sequences for the switch block
`timescale 1ns/10ps
module atxw_top_tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic key_confirm = 1'b0;
    logic key_cancel = 1'b0;
    logic supply_on = 1'b1;
    logic pin1_on = 1'b1;
    logic cfg_valid = 1'b0;
    logic [1:0] cfg_len = 2'h0;
    logic [7:0] cfg_mask = 8'h00;
    logic [7:0] cfg_pulse_len = 8'h00;
    logic [7:0] cfg_sense_sel = 8'h00;
    logic wdog_valid = 1'b0;
    logic [7:0] wdog_timeout = 8'h00;
    logic status_req = 1'b0;
    logic sense_supply, sense_pin1, reset_line_in, power_line_in;
    logic reset_line_out, reset_line_oe, power_line_out, power_line_oe;
    logic status_valid, status_last, cmd_blocked, display_blank, self_reset;
    logic [7:0] status_byte;
    logic [1:0] msg_sel;
    logic [31:0] drive_cycles;
    logic [7:0] st [15];
    logic seen;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int self_resets = 0;

    always #50 clk = ~clk;

    atxw_host_model i_host (.clk(clk), .reset_line_out(reset_line_out),
        .reset_line_oe(reset_line_oe), .power_line_out(power_line_out),
        .power_line_oe(power_line_oe), .supply_on(supply_on), .pin1_on(pin1_on),
        .reset_line_in(reset_line_in), .power_line_in(power_line_in),
        .sense_supply(sense_supply), .sense_pin1(sense_pin1), .drive_cycles(drive_cycles));

    atxw_top i_dut (.clk(clk), .reset(reset), .key_confirm(key_confirm),
        .key_cancel(key_cancel), .sense_supply(sense_supply), .sense_pin1(sense_pin1),
        .reset_line_in(reset_line_in), .power_line_in(power_line_in),
        .reset_line_out(reset_line_out), .reset_line_oe(reset_line_oe),
        .power_line_out(power_line_out), .power_line_oe(power_line_oe),
        .cfg_valid(cfg_valid), .cfg_len(cfg_len), .cfg_mask(cfg_mask),
        .cfg_pulse_len(cfg_pulse_len), .cfg_sense_sel(cfg_sense_sel),
        .wdog_valid(wdog_valid), .wdog_timeout(wdog_timeout), .status_req(status_req),
        .status_valid(status_valid), .status_byte(status_byte), .status_last(status_last),
        .cmd_blocked(cmd_blocked), .display_blank(display_blank), .self_reset(self_reset),
        .msg_sel(msg_sel));

    task automatic results();
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t %s: seen %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic send_cfg(input logic [1:0] len, input logic [7:0] mask,
                            input logic [7:0] plen, input logic [7:0] sel);
        @(posedge clk);
        cfg_valid <= 1'b1;
        cfg_len <= len;
        cfg_mask <= mask;
        cfg_pulse_len <= plen;
        cfg_sense_sel <= sel;
        @(posedge clk);
        cfg_valid <= 1'b0;
    endtask : send_cfg

    task automatic feed(input logic [7:0] t);
        @(posedge clk);
        wdog_valid <= 1'b1;
        wdog_timeout <= t;
        @(posedge clk);
        wdog_valid <= 1'b0;
    endtask : feed

    // one request, then the stream must run unbroken with last on the final byte
    task automatic read_status();
        int n;
        @(posedge clk);
        status_req <= 1'b1;
        @(posedge clk);
        status_req <= 1'b0;
        n = 0;
        #1;
        while (status_valid !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        for (int i = 0; i < 15; i++) begin
            st[i] = status_byte;
            check({7'h0, status_valid}, 8'h01, "status valid run");
            check({7'h0, status_last}, {7'h0, i == 14}, "status last flag");
            @(posedge clk);
            #1;
        end
        check({7'h0, status_valid}, 8'h00, "status stream end");
    endtask : read_status

    task automatic expect_status(input logic [7:0] m, input logic [7:0] w,
                                 input logic [7:0] s);
        read_status();
        for (int i = 0; i < 15; i++) begin
            if (i != 7 && i != 8 && i != 11) begin
                check(st[i], 8'h00, "status spare byte");
            end
        end
        check(st[7], m, "status mask byte");
        check(st[8], w, "status countdown byte");
        check(st[11], s, "status sense source byte");
    endtask : expect_status

    // sense passes a three-stage synchroniser, so give it time to land
    task automatic set_sense(input logic sup, input logic p1);
        @(posedge clk);
        supply_on <= sup;
        pin1_on <= p1;
        repeat (10) @(posedge clk);
        #1;
    endtask : set_sense

    always @(posedge clk) begin
        cycles++;
        if (self_reset === 1'b1) begin
            self_resets++;
        end
        if (cycles == 20000) begin
            bad_count++;
            $display("BAD t=%0t run did not complete in time", $time);
            results();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check({7'h0, cmd_blocked}, 8'h00, "blocked after reset");
        check({6'h0, msg_sel}, 8'h00, "message after reset");
        check(8'(self_resets), 8'h00, "no self reset from release");
        expect_status(8'h00, 8'h00, 8'h01);
        $display("test defaults done");
        // watchdog-active bit is status only; writing it must not stick
        send_cfg(2'h1, 8'hff, 8'h00, 8'h00);
        expect_status(8'hf7, 8'h00, 8'h01);
        send_cfg(2'h3, 8'h10, 8'h08, 8'h00);
        expect_status(8'h10, 8'h00, 8'h00);
        set_sense(1'b1, 1'b0);
        check({7'h0, display_blank}, 8'h01, "blank on pin sense low");
        set_sense(1'b0, 1'b1);
        check({7'h0, display_blank}, 8'h00, "supply ignored when pin chosen");
        set_sense(1'b0, 1'b0);
        check({7'h0, display_blank}, 8'h01, "blank while host down");
        send_cfg(2'h2, 8'h00, 8'h10, 8'h01);
        repeat (2) @(posedge clk);
        #1;
        check({7'h0, display_blank}, 8'h00, "no blank when disabled");
        send_cfg(2'h0, 8'h10, 8'h10, 8'h01);
        expect_status(8'h00, 8'h00, 8'h00);
        $display("test config and sense done");
        feed(8'h05);
        expect_status(8'h08, 8'h05, 8'h00);
        feed(8'hff);
        expect_status(8'h08, 8'hff, 8'h00);
        feed(8'h00);
        expect_status(8'h00, 8'h00, 8'h00);
        $display("test watchdog done");
        @(posedge clk);
        pin1_on <= 1'b1;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk);
            #1;
            if (self_reset === 1'b1) begin
                seen = 1'b1;
            end
        end
        check({7'h0, seen}, 8'h01, "self reset on sense rise");
        check(drive_cycles[7:0], 8'h00, "lines never driven");
        check({6'h0, reset_line_in, power_line_in}, 8'h03, "lines left floating");
        // settings held as boot state must survive the self reset
        expect_status(8'h00, 8'h00, 8'h00);
        $display("test sense rise done");
        results();
    end
endmodule : atxw_top_tb_top
